// [design/ftu_timers.sv]
// ftu_timers: two 8-bit and two 16-bit down-counting timers with prescalers
// assumes a cpu-side byte port on i_mclk; pins arrive unsynchronised
//
// Summary of operation
// - reload value n divides by n+1
// - count down, underflow after zero, reload
// - underflow sets that timer's request flag
// - divider takes on-chip oscillator when bits 10
// - fixed prescaler counts clock divided by sixteen
// - 8-bit write loads latch and counter
// - 8-bit read returns live count
// - fixed timer steps on prescaler underflow
// - fixed timer never stops
// - mode timer has four modes, source select
// - pulse mode toggles counter pin on underflow
// - pulse starts high with polarity 0
// - secondary output drives inverted pulse when enabled
// - event mode counts chosen counter pin edge
// - width mode gates count by pin level
// - stop bit halts mode timer in all modes
// - pin request on falling edge, polarity 0
// - wide timer source choices, seventh alternate
// - wide timers underflow after 0000, reload, flag
// - write-control 1 writes latch only
`timescale 1ns/1ps
`include "ftu_defines.svh"
module ftu_timers (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [1:0] i_clk_div_sel,
  input wire logic i_onchip_osc,
  input wire logic i_counter_pin,
  input wire logic [7:0] i_wdata,
  input wire logic i_fixed_prescaler_reg_wr,
  input wire logic i_fixed_timer_reg_wr,
  input wire logic i_mode_prescaler_reg_wr,
  input wire logic i_mode_timer_wr,
  input wire logic i_wide_timer_a_low_wr,
  input wire logic i_wide_timer_a_high_wr,
  input wire logic i_wide_timer_b_low_wr,
  input wire logic i_wide_timer_b_high_wr,
  input wire logic i_wide_timer_a_high_rd,
  input wire logic i_wide_timer_b_high_rd,
  input wire logic [1:0] i_mode,
  input wire logic i_edge_pol,
  input wire logic i_count_stop,
  input wire logic i_sec_out_en,
  input wire logic [1:0] i_mode_src_sel,
  input wire logic [2:0] i_wide_a_src_sel,
  input wire logic [2:0] i_wide_b_src_sel,
  input wire logic i_wide_a_latch_only,
  input wire logic i_wide_b_latch_only,
  input wire logic [3:0] i_irq_clr,
  output logic [7:0] o_fixed_prescaler_reg,
  output logic [7:0] o_fixed_timer_reg,
  output logic [7:0] o_mode_prescaler_reg,
  output logic [7:0] o_mode_timer,
  output logic [7:0] o_wide_timer_a_low,
  output logic [7:0] o_wide_timer_a_high,
  output logic [7:0] o_wide_timer_b_low,
  output logic [7:0] o_wide_timer_b_high,
  output logic o_fixed_irq,
  output logic o_mode_irq,
  output logic o_wide_a_irq,
  output logic o_wide_b_irq,
  output logic o_counter_pin_irq,
  output logic o_counter_pin_out,
  output logic o_counter_pin_oe_n,
  output logic o_secondary_timer_output
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one step of a reloading down-counter; uf high when it wraps
  // a write on the same edge overrides this step in the callers
  function automatic logic [16:0] ftu_step16(input logic [15:0] cnt, input logic [15:0] lat,
                                             input logic en);
    if (!en)
      ftu_step16 = {1'b0, cnt};
    else if (cnt == 16'h0000)
      ftu_step16 = {1'b1, lat};
    else
      ftu_step16 = {1'b0, cnt - 16'h0001};
  endfunction

  // code 7 picks no tap at all, so that timer rests
  function automatic logic ftu_src(input logic [2:0] sel, input logic [7:0] tick,
                                   input logic alt);
    case (sel)
      `FTU_SRC_DIV2: ftu_src = tick[0];
      `FTU_SRC_DIV16: ftu_src = tick[3];
      `FTU_SRC_DIV32: ftu_src = tick[4];
      `FTU_SRC_DIV64: ftu_src = tick[5];
      `FTU_SRC_DIV128: ftu_src = tick[6];
      `FTU_SRC_DIV256: ftu_src = tick[7];
      `FTU_SRC_ALT: ftu_src = alt;
      default: ftu_src = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and divider
  // ------------------------------------------------------------
  // the _d_r flops are a third stage, read only by the edge detectors
  logic [1:0] pin_sync_r, osc_sync_r;
  logic pin_d_r, osc_d_r;
  logic [7:0] div_r, div_nxt;
  logic [7:0] tick;
  logic div_src, pin_rise, pin_fall, osc_tick, ones_run;

  always_comb begin
    osc_tick = osc_sync_r[1] & ~osc_d_r;
    pin_rise = pin_sync_r[1] & ~pin_d_r;
    pin_fall = ~pin_sync_r[1] & pin_d_r;
    div_src = (i_clk_div_sel == `FTU_CLKDIV_ONCHIP) ? osc_tick : 1'b1;
    div_nxt = div_src ? div_r + 8'h01 : div_r;
    // tick[k]: one pulse per 2^(k+1) source counts, a running and of the low bits
    ones_run = div_src;
    for (int k = 0; k < 8; k++) begin
      ones_run = ones_run & div_r[k];
      tick[k] = ones_run;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_sync_r <= 2'b00;
      osc_sync_r <= 2'b00;
      pin_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      div_r <= 8'h00;
    end else begin
      pin_sync_r <= {pin_sync_r[0], i_counter_pin};
      osc_sync_r <= {osc_sync_r[0], i_onchip_osc};
      pin_d_r <= pin_sync_r[1];
      osc_d_r <= osc_sync_r[1];
      div_r <= div_nxt;
    end
  end

  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  logic [7:0] fp_r, fp_nxt, fpl_r, fpl_nxt, ft_r, ft_nxt, ftl_r, ftl_nxt;
  logic [7:0] mp_r, mp_nxt, mpl_r, mpl_nxt, mt_r, mt_nxt, mtl_r, mtl_nxt;
  logic [15:0] wa_r, wa_nxt, wal_r, wal_nxt, wb_r, wb_nxt, wbl_r, wbl_nxt;
  logic [7:0] wa_buf_r, wa_buf_nxt, wb_buf_r, wb_buf_nxt;
  logic [7:0] wa_rdl_r, wa_rdl_nxt, wb_rdl_r, wb_rdl_nxt;
  logic [3:0] irq_r, irq_nxt;
  logic cirq_r, cirq_nxt, pout_r, pout_nxt;
  logic [16:0] s_fp, s_ft, s_mp, s_mt, s_wa, s_wb;
  logic m_src, m_run, mode_pulse, mode_ev, mode_wd;
  logic [3:0] uf;

  always_comb begin
    mode_pulse = i_mode == ftu_pkg::FTU_MODE_PULSE;
    mode_ev = i_mode == ftu_pkg::FTU_MODE_EVENT;
    mode_wd = i_mode == ftu_pkg::FTU_MODE_WIDTH;
    // no stop input reaches the fixed pair: it always runs
    s_fp = ftu_step16({8'h00, fp_r}, {8'h00, fpl_r}, tick[`FTU_FIX_DIV_BIT]);
    s_ft = ftu_step16({8'h00, ft_r}, {8'h00, ftl_r}, s_fp[16]);
    if (mode_ev)
      m_src = i_edge_pol ? pin_fall : pin_rise;
    else
      m_src = ftu_src({1'b0, i_mode_src_sel}, tick, 1'b0);
    m_run = !i_count_stop && (!mode_wd || (pin_sync_r[1] ^ i_edge_pol));
    s_mp = ftu_step16({8'h00, mp_r}, {8'h00, mpl_r}, m_src && m_run);
    s_mt = ftu_step16({8'h00, mt_r}, {8'h00, mtl_r}, s_mp[16]);
    s_wa = ftu_step16(wa_r, wal_r, ftu_src(i_wide_a_src_sel, tick, osc_tick));
    s_wb = ftu_step16(wb_r, wbl_r, ftu_src(i_wide_b_src_sel, tick, s_wa[16]));
    uf = {s_wb[16], s_wa[16], s_mt[16], s_ft[16]};

    fpl_nxt = i_fixed_prescaler_reg_wr ? i_wdata : fpl_r;
    fp_nxt = i_fixed_prescaler_reg_wr ? i_wdata : s_fp[7:0];
    ftl_nxt = i_fixed_timer_reg_wr ? i_wdata : ftl_r;
    ft_nxt = i_fixed_timer_reg_wr ? i_wdata : s_ft[7:0];
    mpl_nxt = i_mode_prescaler_reg_wr ? i_wdata : mpl_r;
    mp_nxt = i_mode_prescaler_reg_wr ? i_wdata : s_mp[7:0];
    mtl_nxt = i_mode_timer_wr ? i_wdata : mtl_r;
    mt_nxt = i_mode_timer_wr ? i_wdata : s_mt[7:0];

    // low byte waits in a buffer so the counter never sees half a word
    wa_buf_nxt = i_wide_timer_a_low_wr ? i_wdata : wa_buf_r;
    wb_buf_nxt = i_wide_timer_b_low_wr ? i_wdata : wb_buf_r;
    wal_nxt = i_wide_timer_a_high_wr ? {i_wdata, wa_buf_r} : wal_r;
    wbl_nxt = i_wide_timer_b_high_wr ? {i_wdata, wb_buf_r} : wbl_r;
    wa_nxt = (i_wide_timer_a_high_wr && !i_wide_a_latch_only) ?
             {i_wdata, wa_buf_r} : s_wa[15:0];
    wb_nxt = (i_wide_timer_b_high_wr && !i_wide_b_latch_only) ?
             {i_wdata, wb_buf_r} : s_wb[15:0];
    // low byte frozen at the high read, so the pair read stays matched
    wa_rdl_nxt = i_wide_timer_a_high_rd ? wa_r[7:0] : wa_rdl_r;
    wb_rdl_nxt = i_wide_timer_b_high_rd ? wb_r[7:0] : wb_rdl_r;

    // set wins over a clear in the same cycle
    irq_nxt = (irq_r & ~i_irq_clr) | uf;
    // the interrupt edge is opposite to the counting edge
    // a new edge beats a clear in the same cycle, so no request is lost
    cirq_nxt = (cirq_r & ~i_irq_clr[0]) | (i_edge_pol ? pin_rise : pin_fall);

    // parked at its start level outside pulse mode, ready for entry
    if (!mode_pulse)
      pout_nxt = ~i_edge_pol;
    else
      pout_nxt = pout_r ^ uf[1];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      // all ones: longest period until software first writes
      fp_r <= `FTU_RST_BYTE;
      fpl_r <= `FTU_RST_BYTE;
      ft_r <= `FTU_RST_BYTE;
      ftl_r <= `FTU_RST_BYTE;
      mp_r <= `FTU_RST_BYTE;
      mpl_r <= `FTU_RST_BYTE;
      mt_r <= `FTU_RST_BYTE;
      mtl_r <= `FTU_RST_BYTE;
      wa_r <= `FTU_RST_WORD;
      wal_r <= `FTU_RST_WORD;
      wb_r <= `FTU_RST_WORD;
      wbl_r <= `FTU_RST_WORD;
      wa_buf_r <= 8'h00;
      wb_buf_r <= 8'h00;
      wa_rdl_r <= 8'h00;
      wb_rdl_r <= 8'h00;
      irq_r <= 4'h0;
      cirq_r <= 1'b0;
      pout_r <= 1'b1;
    end else begin
      fp_r <= fp_nxt;
      fpl_r <= fpl_nxt;
      ft_r <= ft_nxt;
      ftl_r <= ftl_nxt;
      mp_r <= mp_nxt;
      mpl_r <= mpl_nxt;
      mt_r <= mt_nxt;
      mtl_r <= mtl_nxt;
      wa_r <= wa_nxt;
      wal_r <= wal_nxt;
      wb_r <= wb_nxt;
      wbl_r <= wbl_nxt;
      wa_buf_r <= wa_buf_nxt;
      wb_buf_r <= wb_buf_nxt;
      wa_rdl_r <= wa_rdl_nxt;
      wb_rdl_r <= wb_rdl_nxt;
      irq_r <= irq_nxt;
      cirq_r <= cirq_nxt;
      pout_r <= pout_nxt;
    end
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_fixed_prescaler_reg <= `FTU_RST_BYTE;
      o_fixed_timer_reg <= `FTU_RST_BYTE;
      o_mode_prescaler_reg <= `FTU_RST_BYTE;
      o_mode_timer <= `FTU_RST_BYTE;
      o_wide_timer_a_low <= 8'h00;
      o_wide_timer_a_high <= `FTU_RST_BYTE;
      o_wide_timer_b_low <= 8'h00;
      o_wide_timer_b_high <= `FTU_RST_BYTE;
      o_fixed_irq <= 1'b0;
      o_mode_irq <= 1'b0;
      o_wide_a_irq <= 1'b0;
      o_wide_b_irq <= 1'b0;
      o_counter_pin_irq <= 1'b0;
      o_counter_pin_out <= 1'b1;
      o_counter_pin_oe_n <= 1'b1;
      o_secondary_timer_output <= 1'b0;
    end else begin
      // next values, so outputs track the internal registers cycle for cycle
      o_fixed_prescaler_reg <= fp_nxt;
      o_fixed_timer_reg <= ft_nxt;
      o_mode_prescaler_reg <= mp_nxt;
      o_mode_timer <= mt_nxt;
      o_wide_timer_a_low <= wa_rdl_nxt;
      o_wide_timer_a_high <= wa_nxt[15:8];
      o_wide_timer_b_low <= wb_rdl_nxt;
      o_wide_timer_b_high <= wb_nxt[15:8];
      o_fixed_irq <= irq_nxt[0];
      o_mode_irq <= irq_nxt[1];
      o_wide_a_irq <= irq_nxt[2];
      o_wide_b_irq <= irq_nxt[3];
      o_counter_pin_irq <= cirq_nxt;
      o_counter_pin_out <= pout_nxt;
      o_counter_pin_oe_n <= ~mode_pulse;
      o_secondary_timer_output <= i_sec_out_en & mode_pulse & ~pout_nxt;
    end
  end
endmodule

// [pkg/ftu_defines.svh]
// ftu_defines.svh: timing counts and field encodings of the four-timer unit
// assumes inclusion by bare name from design files
`ifndef FTU_DEFINES_SVH
`define FTU_DEFINES_SVH
// ------------------------------------------------------------
// resets and clock selection
// ------------------------------------------------------------
`define FTU_RST_BYTE 8'hFF
`define FTU_RST_WORD 16'hFFFF
`define FTU_CLKDIV_ONCHIP 2'b10
`define FTU_FIX_DIV_BIT 3
// ------------------------------------------------------------
// wide timer source codes
// ------------------------------------------------------------
`define FTU_SRC_DIV2 3'h0
`define FTU_SRC_DIV16 3'h1
`define FTU_SRC_DIV32 3'h2
`define FTU_SRC_DIV64 3'h3
`define FTU_SRC_DIV128 3'h4
`define FTU_SRC_DIV256 3'h5
`define FTU_SRC_ALT 3'h6
`endif

// [pkg/ftu_pkg.sv]
// ftu_pkg: types of the four-timer unit
// assumes the defines header is compiled alongside
package ftu_pkg;
  typedef enum logic [1:0] {
    FTU_MODE_TIMER,
    FTU_MODE_PULSE,
    FTU_MODE_EVENT,
    FTU_MODE_WIDTH
  } ftu_mode_t;
endpackage

// [verif/ftu_pin_src.sv]
// ftu_pin_src: outside pulse source and load on the counter pin
// assumes the bench moves the level just after a clock edge
`timescale 1ns/1ps
module ftu_pin_src (
  input wire logic i_level,
  input wire logic i_out,
  input wire logic i_oe_n,
  output logic o_pin
);
  // device wins while its enable is low; source otherwise
  assign o_pin = i_oe_n ? i_level : i_out;
endmodule

// [verif/ftu_timers_monitor.sv]
// ftu_timers_monitor: port-level checks of the four-timer unit
// assumes binding into ftu_timers, one clock i_mclk
`timescale 1ns/1ps
module ftu_timers_monitor (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [1:0] i_clk_div_sel,
  input wire logic [7:0] i_wdata,
  input wire logic i_fixed_prescaler_reg_wr,
  input wire logic i_fixed_timer_reg_wr,
  input wire logic i_mode_timer_wr,
  input wire logic i_wide_timer_a_high_wr,
  input wire logic [1:0] i_mode,
  input wire logic i_count_stop,
  input wire logic i_sec_out_en,
  input wire logic [2:0] i_wide_a_src_sel,
  input wire logic i_wide_a_latch_only,
  input wire logic [7:0] o_fixed_prescaler_reg,
  input wire logic [7:0] o_fixed_timer_reg,
  input wire logic [7:0] o_mode_timer,
  input wire logic [7:0] o_wide_timer_a_high,
  input wire logic o_fixed_irq,
  input wire logic o_mode_irq,
  input wire logic o_counter_pin_out,
  input wire logic o_counter_pin_oe_n,
  input wire logic o_secondary_timer_output
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_pulse_held;
    i_mode == ftu_pkg::FTU_MODE_PULSE && $past(i_mode) == ftu_pkg::FTU_MODE_PULSE;
  endsequence
  chk_fixed_wr_load: assert property (i_fixed_timer_reg_wr |=>
    o_fixed_timer_reg == $past(i_wdata)) else $error("fixed timer write not loaded");
  chk_stop_holds: assert property (i_count_stop && $past(i_count_stop) && !i_mode_timer_wr
    |=> $stable(o_mode_timer)) else $error("stopped mode timer moved");
  chk_fixed_uflow_flag: assert property ($rose(o_fixed_irq) |->
    $past(o_fixed_timer_reg) == 8'h00) else $error("fixed flag without underflow");
  chk_mode_uflow_flag: assert property ($rose(o_mode_irq) |->
    $past(o_mode_timer) == 8'h00) else $error("mode flag without underflow");
  // the osc path may be idle, so only the crystal path must keep moving
  chk_fixed_runs_free: assert property (@(posedge i_mclk)
    disable iff (i_rst || i_clk_div_sel == 2'b10)
    o_fixed_prescaler_reg != 8'h00 && !i_fixed_prescaler_reg_wr
    |-> ##[1:20] $changed(o_fixed_prescaler_reg)) else $error("fixed prescaler stalled");
  chk_pulse_toggle: assert property (s_pulse_held ##0 $changed(o_counter_pin_out)
    |-> $past(o_mode_timer) == 8'h00) else $error("pin toggled without underflow");
  chk_sec_inverse: assert property (s_pulse_held ##0 i_sec_out_en && $past(i_sec_out_en)
    |-> o_secondary_timer_output == !o_counter_pin_out) else $error("secondary not inverse");
  chk_pin_drive_en: assert property (i_mode == $past(i_mode) |->
    o_counter_pin_oe_n == (i_mode != 2'h1)) else $error("pin enable wrong for mode");
  chk_wide_commit: assert property (i_wide_timer_a_high_wr && !i_wide_a_latch_only
    |=> o_wide_timer_a_high == $past(i_wdata)) else $error("wide write not in counter");
  chk_latch_only: assert property (i_wide_timer_a_high_wr && i_wide_a_latch_only
    && i_wide_a_src_sel == 3'h7 && $past(i_wide_a_src_sel) == 3'h7
    |=> $stable(o_wide_timer_a_high)) else $error("latch-only write hit counter");
endmodule

// [verif/ftu_timers_tb.sv]
// ftu_timers_tb: directed checks of the four-timer unit
// assumes ftu_timers and the pin source model are compiled first
`timescale 1ns/1ps
module ftu_timers_tb;
  logic i_mclk = 0, i_rst = 1, i_onchip_osc = 0, i_counter_pin, i_edge_pol = 0, lvl = 0;
  logic i_count_stop = 1, i_sec_out_en = 1, i_wide_a_latch_only = 0, i_wide_b_latch_only = 0;
  logic [1:0] i_clk_div_sel = 0, i_mode = 0, i_mode_src_sel = 0;
  logic [2:0] i_wide_a_src_sel = 3'h7, i_wide_b_src_sel = 3'h7, oc = 0;
  logic [3:0] i_irq_clr = 0;
  logic [9:0] ws = 0;
  logic [7:0] i_wdata = 0, o_fixed_prescaler_reg, o_fixed_timer_reg, o_mode_prescaler_reg,
    o_mode_timer, o_wide_timer_a_low, o_wide_timer_a_high, o_wide_timer_b_low, o_wide_timer_b_high;
  logic o_fixed_irq, o_mode_irq, o_wide_a_irq, o_wide_b_irq, o_counter_pin_irq, o_counter_pin_out,
    o_counter_pin_oe_n, o_secondary_timer_output, osc_on = 0;
  logic i_fixed_prescaler_reg_wr, i_fixed_timer_reg_wr, i_mode_prescaler_reg_wr, i_mode_timer_wr,
    i_wide_timer_a_low_wr, i_wide_timer_a_high_wr, i_wide_timer_b_low_wr, i_wide_timer_b_high_wr,
    i_wide_timer_a_high_rd, i_wide_timer_b_high_rd;
  int bad_count = 0, samples_checked = 0, n, dv[6] = '{2, 16, 32, 64, 128, 256};
  logic [7:0] v;
  wire [3:0] irqs = {o_wide_b_irq, o_wide_a_irq, o_mode_irq, o_fixed_irq};
  assign {i_wide_timer_b_high_rd, i_wide_timer_a_high_rd, i_wide_timer_b_high_wr,
    i_wide_timer_b_low_wr, i_wide_timer_a_high_wr, i_wide_timer_a_low_wr, i_mode_timer_wr,
    i_mode_prescaler_reg_wr, i_fixed_timer_reg_wr, i_fixed_prescaler_reg_wr} = ws;
  ftu_timers dut (.*);
  ftu_pin_src u_src (.i_level(lvl), .i_out(o_counter_pin_out), .i_oe_n(o_counter_pin_oe_n),
    .o_pin(i_counter_pin));
  initial forever #4 i_mclk = ~i_mclk;
  // osc runs at one eighth of mclk, phase set by the bench
  always @(posedge i_mclk) if (osc_on) begin
    oc <= oc + 3'h1;
    i_onchip_osc <= oc[2];
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input int k, input logic [7:0] d);
    @(posedge i_mclk);
    ws[k] <= 1'b1;
    i_wdata <= d;
    @(posedge i_mclk);
    ws <= 0;
    #1;
  endtask
  task clr(input int b);
    @(posedge i_mclk);
    i_irq_clr[b] <= 1'b1;
    @(posedge i_mclk);
    i_irq_clr <= 0;
    #1;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // cycles from the previous clear to the next flag, plus the clear itself
  task wirq(input int b);
    n = 0;
    while (irqs[b] !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      give_verdict;
    end
    clr(b);
    n += 2;
  endtask
  task go(input logic s, input logic [1:0] m, input logic p);
    @(posedge i_mclk);
    i_count_stop <= s;
    i_mode <= m;
    i_edge_pol <= p;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 0;
    wr(2, 8'h01);
    chk(o_mode_prescaler_reg, 8'h01);
    wr(3, 8'h02);
    repeat (10) @(posedge i_mclk);
    #1;
    chk(o_mode_timer, 8'h02);
    for (int s = 0; s < 4; s++) begin
      i_mode_src_sel <= s[1:0];
      go(0, 0, 0);
      wirq(1);
      wirq(1);
      chk(n, dv[s] * 6);
    end
    $display("mode timer test done");
    i_mode_src_sel <= 0;
    go(1, 1, 0);
    clr(1);
    chk({o_counter_pin_oe_n, o_counter_pin_out, o_secondary_timer_output}, 3'h2);
    go(0, 1, 0);
    wirq(1);
    chk({o_counter_pin_out, o_secondary_timer_output}, 2'h1);
    go(1, 0, 1);
    i_sec_out_en <= 1'b0;
    go(1, 1, 1);
    chk({o_counter_pin_out, o_secondary_timer_output}, 2'h0);
    $display("pulse test done");
    go(1, 2, 0);
    wr(2, 8'h00);
    wr(3, 8'h10);
    go(0, 2, 0);
    repeat (4) begin
      lvl <= 1'b1;
      repeat (6) @(posedge i_mclk);
      clr(0);
      lvl <= 1'b0;
      repeat (6) @(posedge i_mclk);
      #1;
      chk(o_counter_pin_irq, 1'b1);
    end
    chk(o_mode_timer, 8'h0c);
    go(0, 2, 1);
    clr(0);
    chk(o_counter_pin_irq, 1'b0);
    lvl <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    chk(o_counter_pin_irq, 1'b1);
    lvl <= 1'b0;
    // let the falling edge pass before the reload, or it is counted
    repeat (6) @(posedge i_mclk);
    wr(3, 8'h20);
    go(0, 3, 0);
    repeat (20) @(posedge i_mclk);
    #1;
    chk(o_mode_timer, 8'h20);
    lvl <= 1'b1;
    repeat (20) @(posedge i_mclk);
    lvl <= 1'b0;
    repeat (6) @(posedge i_mclk);
    #1;
    v = o_mode_timer;
    repeat (20) @(posedge i_mclk);
    #1;
    chk({o_mode_timer == v, v < 8'h20}, 2'h3);
    $display("pin modes test done");
    wr(4, 8'h34);
    wr(5, 8'h12);
    chk(o_wide_timer_a_high, 8'h12);
    wr(8, 8'h00);
    chk(o_wide_timer_a_low, 8'h34);
    i_wide_a_latch_only <= 1'b1;
    wr(4, 8'h78);
    wr(5, 8'h56);
    chk(o_wide_timer_a_high, 8'h12);
    i_wide_a_latch_only <= 1'b0;
    wr(4, 8'h99);
    wr(8, 8'h00);
    chk({o_wide_timer_a_high, o_wide_timer_a_low}, 16'h1234);
    wr(4, 8'h01);
    wr(5, 8'h00);
    for (int s = 0; s < 6; s++) begin
      i_wide_a_src_sel <= s[2:0];
      wirq(2);
      wirq(2);
      chk(n, dv[s] * 2);
    end
    i_wide_a_src_sel <= 3'h0;
    wr(6, 8'h02);
    wr(7, 8'h00);
    i_wide_b_src_sel <= 3'h6;
    wirq(3);
    wirq(3);
    chk(n, 12);
    wr(9, 8'h00);
    chk({o_wide_timer_b_high, 7'h00, o_wide_timer_b_low < 8'h03}, 16'h0001);
    $display("wide timer test done");
    wr(0, 8'h01);
    chk(o_fixed_prescaler_reg, 8'h01);
    wr(1, 8'h01);
    chk(o_fixed_timer_reg, 8'h01);
    wirq(0);
    wirq(0);
    chk(n, 64);
    i_clk_div_sel <= 2'b10;
    osc_on <= 1'b1;
    wirq(0);
    wirq(0);
    chk(n, 512);
    $display("fixed timer test done");
    give_verdict;
  end
endmodule
bind ftu_timers ftu_timers_monitor u_mon (.*);
